/* File: design/cms_pkg.sv */
// Purpose: Shared constants for the streaming complex multiplier
// Assumes: APB register window of 12 address bits, 32-bit data
// Notes: Offsets are byte addresses, one aligned word per register

package cms_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int CMS_AW = 12;
  localparam logic [CMS_AW-1:0] CMS_ADDR_CTRL = 12'h000;
  localparam logic [CMS_AW-1:0] CMS_ADDR_STATUS = 12'h004;
  localparam logic [CMS_AW-1:0] CMS_ADDR_COUNT = 12'h008;

  // Control register fields
  localparam int CMS_CTRL_BLOCK_BIT = 0;
  localparam int CMS_CTRL_LAST_LSB = 1;
  localparam int CMS_CTRL_ROUND_BIT = 4;
  localparam int CMS_CTRL_W = 5;
  localparam logic [CMS_CTRL_W-1:0] CMS_CTRL_RST = 5'h11;

  // Status register fields
  localparam int CMS_STAT_FULL_LSB = 0;
  localparam int CMS_STAT_OUTV_BIT = 3;
  localparam int CMS_STAT_RST_BIT = 4;

  // ----------------------------------------------------------------
  // Output last-marker selection
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMS_LAST_NONE = 3'b000,
    CMS_LAST_A = 3'b001,
    CMS_LAST_B = 3'b010,
    CMS_LAST_CTRL = 3'b011,
    CMS_LAST_OR = 3'b100,
    CMS_LAST_AND = 3'b101
  } cms_last_type;

  // ----------------------------------------------------------------
  // Pipeline and multiplier sizing
  // ----------------------------------------------------------------
  localparam int CMS_AUTO_DEPTH = 4;
  localparam int CMS_MIN_DEPTH = 2;
  localparam int CMS_TAIL_STAGES = 2;
  localparam int CMS_MULT_TILE = 18;

endpackage

/* File: design/cms_cmul.sv */
// Purpose: Pipelined complex product core with valid and sideband
// Assumes: Operands signed, i_en is the common advance strobe
// Notes: Depth counts the product stage and the combine stage

`timescale 1ns/100ps
`default_nettype none

module cms_cmul #(
  parameter int AW = 16,
  parameter int BW = 16,
  parameter int PW = 33,
  parameter int SBW = 4,
  parameter bit FOUR = 1'b1,
  parameter int DEPTH = 4
) (
  input wire logic i_clk, // System clock
  input wire logic i_clear, // Synchronous clear of valid flags
  input wire logic i_en, // Pipeline advance
  input wire logic i_valid, // Operands valid
  input wire logic [SBW-1:0] i_sb, // Sideband travelling along
  input wire logic signed [AW-1:0] i_a_re, // A real part
  input wire logic signed [AW-1:0] i_a_im, // A imaginary part
  input wire logic signed [BW-1:0] i_b_re, // B real part
  input wire logic signed [BW-1:0] i_b_im, // B imaginary part
  output logic o_valid, // Product valid
  output logic [SBW-1:0] o_sb, // Delayed sideband
  output logic signed [PW-1:0] o_re, // Product real part
  output logic signed [PW-1:0] o_im // Product imaginary part
);

  localparam int XW = PW + 1;

  logic [DEPTH-1:0] vld;
  logic [SBW-1:0] sb [DEPTH];
  logic signed [PW-1:0] re [1:DEPTH-1];
  logic signed [PW-1:0] im [1:DEPTH-1];
  logic signed [XW-1:0] k1, k2, k3, k4;

  // ----------------------------------------------------------------
  // Product stage, three or four real multipliers
  // ----------------------------------------------------------------
  generate
    if (FOUR) begin : g_m4
      // Four independent products for highest clock rate
      always_ff @(posedge i_clk) begin
        if (i_en) begin
          k1 <= XW'(i_a_re) * XW'(i_b_re);
          k2 <= XW'(i_a_im) * XW'(i_b_im);
          k3 <= XW'(i_a_re) * XW'(i_b_im);
          k4 <= XW'(i_a_im) * XW'(i_b_re);
        end
      end
      // Combine cross products
      always_ff @(posedge i_clk) begin
        if (i_en) begin
          re[1] <= PW'(k1 - k2);
          im[1] <= PW'(k3 + k4);
        end
      end
    end else begin : g_m3
      always_ff @(posedge i_clk) begin
        if (i_en) begin
          k1 <= XW'(i_b_re) * (XW'(i_a_re) + XW'(i_a_im));
          k2 <= XW'(i_a_re) * (XW'(i_b_im) - XW'(i_b_re));
          k3 <= XW'(i_a_im) * (XW'(i_b_re) + XW'(i_b_im));
        end
      end
      assign k4 = '0;
      // Shared term gives both parts
      always_ff @(posedge i_clk) begin
        if (i_en) begin
          re[1] <= PW'(k1 - k3);
          im[1] <= PW'(k1 + k2);
        end
      end
    end
  endgenerate

  // Valid flags shift through every stage
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      vld <= '0;
    end else if (i_en) begin
      vld <= {vld[DEPTH-2:0], i_valid};
    end
  end

  // Sideband through the first two stages
  always_ff @(posedge i_clk) begin
    if (i_en) begin
      sb[0] <= i_sb;
      sb[1] <= sb[0];
    end
  end

  // ----------------------------------------------------------------
  // Extra delay stages for the configured latency
  // ----------------------------------------------------------------
  generate
    for (genvar i = 2; i < DEPTH; i++) begin : g_dly
      always_ff @(posedge i_clk) begin
        if (i_en) begin
          sb[i] <= sb[i-1];
          re[i] <= re[i-1];
          im[i] <= im[i-1];
        end
      end
    end
  endgenerate

  assign o_valid = vld[DEPTH-1];
  assign o_sb = sb[DEPTH-1];
  assign o_re = re[DEPTH-1];
  assign o_im = im[DEPTH-1];

endmodule

`default_nettype wire

/* File: design/cms_top.sv */
// Purpose: Streaming complex multiplier with APB control
// Assumes: Single clock, all stream partners on the same clock
// Notes: Operand words carry the real part low, imaginary part high
//
// Added by the designer: the APB register port and the register addresses.

`timescale 1ns/100ps
`default_nettype none

module cms_top import cms_pkg::*; #(
  parameter int AW = 16, // operand_a_width
  parameter int BW = 16, // operand_b_width
  parameter int OW = 33, // Output part width
  parameter bit ROUND_RANDOM = 1'b0, // Add control channel
  parameter int CTW = 8, // Control data width
  parameter bit HAS_A_LAST = 1'b1,
  parameter bit HAS_B_LAST = 1'b1,
  parameter bit HAS_C_LAST = 1'b0,
  parameter bit HAS_A_USER = 1'b0,
  parameter bit HAS_B_USER = 1'b0,
  parameter bit HAS_C_USER = 1'b0,
  parameter int UAW = 1,
  parameter int UBW = 1,
  parameter int UCW = 1,
  parameter bit FABRIC_MULTIPLIER_BUILD = 1'b0,
  parameter bit OPT_PERF = 1'b0, // Performance goal
  parameter bit LAT_AUTO = 1'b1,
  parameter int MIN_LATENCY = 4
) (
  input wire logic i_ref_clk, // 20 MHz clock
  input wire logic i_rst, // Sync reset, high
  input wire logic i_stream_rst_n, // Stream reset, low
  input wire logic i_aclken, // Clock enable
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB write
  input wire logic [CMS_AW-1:0] i_paddr, // APB address
  input wire logic [31:0] i_pwdata, // APB write data
  input wire logic [3:0] i_pstrb, // APB byte strobes
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error
  input wire logic i_a_tvalid, // A valid
  output logic o_a_tready, // A ready
  input wire logic [2*AW-1:0] i_a_tdata, // A {imag, real}
  input wire logic i_a_tlast, // A last
  input wire logic [UAW-1:0] i_a_tuser, // A user
  input wire logic i_b_tvalid, // B valid
  output logic o_b_tready, // B ready
  input wire logic [2*BW-1:0] i_b_tdata, // B {imag, real}
  input wire logic i_b_tlast, // B last
  input wire logic [UBW-1:0] i_b_tuser, // B user
  input wire logic i_ctrl_tvalid, // Control valid
  output logic o_ctrl_tready, // Control ready
  input wire logic [CTW-1:0] i_ctrl_tdata, // Control data
  input wire logic i_ctrl_tlast, // Control last
  input wire logic [UCW-1:0] i_ctrl_tuser, // Control user
  output logic o_dout_tvalid, // Product valid
  input wire logic i_dout_tready, // Product ready
  output logic [2*OW-1:0] o_dout_tdata, // Product {imag, real}
  output logic o_dout_tlast, // Product last
  output logic [UCW+UBW+UAW-1:0] o_dout_tuser // {ctrl, b, a} user
);

  // ----------------------------------------------------------------
  // Derived sizes and structure choice
  // ----------------------------------------------------------------
  localparam int PW = AW + BW + 1;
  localparam int LSB = (OW < PW) ? PW - OW : 0;
  localparam int LSB_M1 = (LSB > 0) ? LSB - 1 : 0;
  localparam int UW = UCW + UBW + UAW;
  localparam int SBW = UW + 2;
  localparam int MAN_DEPTH = MIN_LATENCY - CMS_TAIL_STAGES;
  localparam int DEPTH = LAT_AUTO ? CMS_AUTO_DEPTH :
    ((MAN_DEPTH > CMS_MIN_DEPTH) ? MAN_DEPTH : CMS_MIN_DEPTH);
  localparam logic signed [PW:0] RND_BIAS =
    (LSB > 0) ? (PW+1)'((64'd1 << LSB_M1) - 64'd1) : '0;

  // Multiplier tiles needed for one real product
  function automatic int tiles(input int aw, input int bw);
    return ((aw + CMS_MULT_TILE - 1) / CMS_MULT_TILE) *
      ((bw + CMS_MULT_TILE - 1) / CMS_MULT_TILE);
  endfunction

  localparam int COST3 = 3 * tiles(AW + 1, BW + 1);
  localparam int COST4 = 4 * tiles(AW, BW);
  localparam bit FOUR = FABRIC_MULTIPLIER_BUILD | OPT_PERF |
    (COST3 > COST4);

  // Refuse configurations the logic cannot serve
  generate
    if (AW < 2 || BW < 2 || OW < 2 || CTW < 1) begin : g_bad_w
      $error("cms_top: widths too small");
    end
    if (ROUND_RANDOM && LSB == 0) begin : g_bad_rnd
      $error("cms_top: rounding needs a nonzero output lsb");
    end
    if (MIN_LATENCY < 1) begin : g_bad_lat
      $error("cms_top: latency must be positive");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Stream reset and advance
  // ----------------------------------------------------------------
  logic clear;
  logic advance;
  logic out_xfer;
  logic [CMS_CTRL_W-1:0] ctrl;
  logic blocking;
  logic round_on;
  cms_last_type last_mode;

  // Reset is registered first, so it acts one cycle late
  always_ff @(posedge i_ref_clk) begin
    clear <= i_rst | ~i_stream_rst_n;
  end

  assign advance = i_aclken & (~o_dout_tvalid | i_dout_tready);
  assign out_xfer = i_aclken & o_dout_tvalid & i_dout_tready;
  assign blocking = ctrl[CMS_CTRL_BLOCK_BIT];
  assign round_on = ctrl[CMS_CTRL_ROUND_BIT] & ROUND_RANDOM;
  assign last_mode = cms_last_type'(ctrl[CMS_CTRL_LAST_LSB +: 3]);

  // ----------------------------------------------------------------
  // Input holding words, one per channel
  // ----------------------------------------------------------------
  logic [2:0] full;
  logic [2:0] in_valid;
  logic [2:0] enab;
  logic [2:0] accept;
  logic [2:0] consume;
  logic [2:0] next_full;
  logic fire;

  assign enab = {ROUND_RANDOM, 1'b1, 1'b1};
  assign in_valid = {i_ctrl_tvalid, i_b_tvalid, i_a_tvalid} & enab;
  // Take a word only where its ready is shown, none just after a clear
  assign accept = in_valid & {o_ctrl_tready, o_b_tready, o_a_tready} &
    {3{i_aclken}};

  // Operation start condition per flow-control mode
  always_comb begin
    if (blocking) begin
      fire = advance & (&(full | ~enab));
    end else begin
      fire = advance & (|(full & enab));
    end
  end

  assign consume = full & {3{fire}};
  assign next_full = (full & ~consume) | accept;

  // Occupancy flags and registered readies
  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      full <= '0;
      o_a_tready <= 1'b0;
      o_b_tready <= 1'b0;
      o_ctrl_tready <= 1'b0;
    end else if (i_aclken) begin
      full <= next_full;
      o_a_tready <= ~next_full[0];
      o_b_tready <= ~next_full[1];
      o_ctrl_tready <= ~next_full[2] & ROUND_RANDOM;
    end
  end

  logic [2*AW-1:0] a_data;
  logic [2*BW-1:0] b_data;
  logic c_bit;
  logic [2:0] lasts;
  logic [UAW-1:0] a_user;
  logic [UBW-1:0] b_user;
  logic [UCW-1:0] c_user;

  // Capture words; an idle channel keeps its last word
  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      a_data <= '0;
      b_data <= '0;
      c_bit <= 1'b0;
      lasts <= '0;
      a_user <= '0;
      b_user <= '0;
      c_user <= '0;
    end else begin
      if (accept[0]) begin
        a_data <= i_a_tdata;
        lasts[0] <= i_a_tlast & HAS_A_LAST;
        a_user <= i_a_tuser & {UAW{HAS_A_USER}};
      end
      if (accept[1]) begin
        b_data <= i_b_tdata;
        lasts[1] <= i_b_tlast & HAS_B_LAST;
        b_user <= i_b_tuser & {UBW{HAS_B_USER}};
      end
      if (accept[2]) begin
        c_bit <= i_ctrl_tdata[0];
        lasts[2] <= i_ctrl_tlast & HAS_C_LAST;
        c_user <= i_ctrl_tuser & {UCW{HAS_C_USER}};
      end
    end
  end

  // ----------------------------------------------------------------
  // Output last-marker selection
  // ----------------------------------------------------------------
  logic [2:0] last_mask;
  logic sel_last;

  assign last_mask = {HAS_C_LAST & ROUND_RANDOM, HAS_B_LAST, HAS_A_LAST};

  always_comb begin
    unique case (last_mode)
      CMS_LAST_NONE: sel_last = 1'b0;
      CMS_LAST_A: sel_last = lasts[0];
      CMS_LAST_B: sel_last = lasts[1];
      CMS_LAST_CTRL: sel_last = lasts[2];
      CMS_LAST_OR: sel_last = |(lasts & last_mask);
      CMS_LAST_AND: sel_last = (&(lasts | ~last_mask)) & (|last_mask);
      default: sel_last = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Complex product core
  // ----------------------------------------------------------------
  logic m_valid;
  logic [SBW-1:0] m_sb;
  logic signed [PW-1:0] m_re;
  logic signed [PW-1:0] m_im;

  cms_cmul #(
    .AW(AW),
    .BW(BW),
    .PW(PW),
    .SBW(SBW),
    .FOUR(FOUR),
    .DEPTH(DEPTH)
  ) u_cmul (
    .i_clk(i_ref_clk),
    .i_clear(clear),
    .i_en(advance),
    .i_valid(fire),
    .i_sb({c_bit & round_on, sel_last, c_user, b_user, a_user}),
    .i_a_re(a_data[AW-1:0]),
    .i_a_im(a_data[2*AW-1:AW]),
    .i_b_re(b_data[BW-1:0]),
    .i_b_im(b_data[2*BW-1:BW]),
    .o_valid(m_valid),
    .o_sb(m_sb),
    .o_re(m_re),
    .o_im(m_im)
  );

  // ----------------------------------------------------------------
  // Scaling: round or truncate, then fit the output width
  // ----------------------------------------------------------------
  function automatic logic [OW-1:0] scale(
    input logic signed [PW-1:0] p,
    input logic r
  );
    logic signed [PW:0] s;
    s = {p[PW-1], p};
    if (LSB > 0 && r) begin
      s = (PW+1)'(s + RND_BIAS + (PW+1)'(1));
    end else if (LSB > 0 && ROUND_RANDOM) begin
      s = (PW+1)'(s + RND_BIAS);
    end
    return OW'(s >>> LSB);
  endfunction

  logic r_valid;
  logic [SBW-2:0] r_sb;
  logic [OW-1:0] r_re;
  logic [OW-1:0] r_im;

  // Rounding stage
  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      r_valid <= 1'b0;
      r_sb <= '0;
      r_re <= '0;
      r_im <= '0;
    end else if (advance) begin
      r_valid <= m_valid;
      r_sb <= m_sb[SBW-2:0];
      r_re <= scale(m_re, m_sb[SBW-1]);
      r_im <= scale(m_im, m_sb[SBW-1]);
    end
  end

  // Output register holds until accepted downstream
  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      o_dout_tvalid <= 1'b0;
      o_dout_tdata <= '0;
      o_dout_tlast <= 1'b0;
      o_dout_tuser <= '0;
    end else if (advance) begin
      o_dout_tvalid <= r_valid;
      o_dout_tdata <= {r_im, r_re};
      o_dout_tlast <= r_sb[UW];
      o_dout_tuser <= r_sb[UW-1:0];
    end
  end

  // Delivered product counter
  logic [31:0] count;

  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      count <= '0;
    end else if (out_xfer) begin
      count <= count + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [CMS_AW-1:0] a);
    return (a == CMS_ADDR_CTRL) || (a == CMS_ADDR_STATUS) ||
      (a == CMS_ADDR_COUNT);
  endfunction

  logic access;
  logic [31:0] rd_word;

  assign access = i_psel & i_penable;

  // Read multiplexer
  always_comb begin
    rd_word = '0;
    if (i_paddr == CMS_ADDR_CTRL) begin
      rd_word[CMS_CTRL_W-1:0] = ctrl;
    end else if (i_paddr == CMS_ADDR_STATUS) begin
      rd_word[CMS_STAT_FULL_LSB +: 3] = full;
      rd_word[CMS_STAT_OUTV_BIT] = o_dout_tvalid;
      rd_word[CMS_STAT_RST_BIT] = clear;
    end else if (i_paddr == CMS_ADDR_COUNT) begin
      rd_word = count;
    end
  end

  // Ready one cycle into the access phase
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= access & ~o_pready;
      if (access & ~o_pready) begin
        o_pslverr <= ~mapped(i_paddr);
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // Control register write on the completing edge
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl <= CMS_CTRL_RST;
    end else if (access & o_pready & i_pwrite & i_pstrb[0] &
                 (i_paddr == CMS_ADDR_CTRL)) begin
      ctrl <= i_pwdata[CMS_CTRL_W-1:0];
    end
  end

endmodule

`default_nettype wire

/* File: sim/cms_chk.sv */
// Purpose: Port checks for the complex multiplier
// Assumes: One clock, synchronous resets
// Notes: A stream clear lands two edges after it is seen
`timescale 1ns/100ps
`default_nettype none
module cms_chk #(
  parameter int OW = 33
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_stream_rst_n, // Stream reset
  input wire logic i_aclken, // Enable
  input wire logic i_penable, // Access
  input wire logic o_pready, // Ready
  input wire logic i_a_tvalid, // A valid
  input wire logic o_a_tready, // A ready
  input wire logic i_b_tvalid, // B valid
  input wire logic o_b_tready, // B ready
  input wire logic i_ctrl_tvalid, // C valid
  input wire logic o_ctrl_tready, // C ready
  input wire logic o_dout_tvalid, // Out valid
  input wire logic i_dout_tready, // Out ready
  input wire logic [2*OW-1:0] o_dout_tdata // Out data
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  logic run;
  logic srst_q;
  // No clear request seen one edge earlier
  always_ff @(posedge i_ref_clk) begin
    srst_q <= i_stream_rst_n && !i_rst;
  end
  // No clear on its way
  assign run = i_stream_rst_n && !i_rst && srst_q;
  property p_hold;
    run && o_dout_tvalid && !(i_dout_tready && i_aclken)
      |=> o_dout_tvalid && $stable(o_dout_tdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("product dropped");
  property p_a_drop;
    i_a_tvalid && o_a_tready && i_aclken |=> !o_a_tready;
  endproperty
  a_a_drop: assert property (p_a_drop)
    else $error("A ready held");
  property p_b_drop;
    i_b_tvalid && o_b_tready && i_aclken |=> !o_b_tready;
  endproperty
  a_b_drop: assert property (p_b_drop)
    else $error("B ready held");
  property p_c_drop;
    i_ctrl_tvalid && o_ctrl_tready && i_aclken |=> !o_ctrl_tready;
  endproperty
  a_c_drop: assert property (p_c_drop)
    else $error("control ready held");
  property p_freeze;
    run && !i_aclken |=> $stable(o_dout_tvalid) && $stable(o_a_tready)
      && $stable(o_dout_tdata);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("moved while disabled");
  property p_clear;
    !i_stream_rst_n |-> ##2 !(o_dout_tvalid || o_a_tready || o_b_tready
      || o_ctrl_tready);
  endproperty
  a_clear: assert property (p_clear)
    else $error("stream not cleared");
  property p_late;
    run ##1 (!i_stream_rst_n && o_dout_tvalid && !i_aclken)
      |=> o_dout_tvalid;
  endproperty
  a_late: assert property (p_late)
    else $error("clear came too early");
  property p_pready;
    $rose(i_penable) |=> o_pready;
  endproperty
  a_pready: assert property (p_pready)
    else $error("bus answer late");
  c_take: cover property (o_dout_tvalid && i_dout_tready && i_aclken);
  c_stall: cover property (o_dout_tvalid && !i_dout_tready);
  c_pulse: cover property (!i_stream_rst_n ##1 i_stream_rst_n);
endmodule
bind cms_top cms_chk #(.OW(OW)) i_cms_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_stream_rst_n(i_stream_rst_n),
  .i_aclken(i_aclken), .i_penable(i_penable), .o_pready(o_pready),
  .i_a_tvalid(i_a_tvalid), .o_a_tready(o_a_tready),
  .i_b_tvalid(i_b_tvalid), .o_b_tready(o_b_tready),
  .i_ctrl_tvalid(i_ctrl_tvalid), .o_ctrl_tready(o_ctrl_tready),
  .o_dout_tvalid(o_dout_tvalid), .i_dout_tready(i_dout_tready),
  .o_dout_tdata(o_dout_tdata)
);
`default_nettype wire

/* File: sim/cms_partner.sv */
// Purpose: Operand producers and product consumer
// Assumes: The bench queues words as {last, data}
// Notes: Idle data lines toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module cms_partner #(
  parameter int DW = 24
) (
  input wire logic i_clk, // Clock
  input wire logic i_aclken, // Enable
  input wire logic [1:0] i_mode, // 0 go, 1 random, 2 hold
  input wire logic [2:0] i_tready, // {c,b,a} ready
  output logic [2:0] o_tvalid, // {c,b,a} valid
  output logic [16:0] o_word [3], // {last, data}
  input wire logic i_dout_tvalid, // Product valid
  input wire logic [DW-1:0] i_dout_tdata, // Product data
  input wire logic i_dout_tlast, // Product last
  output logic o_dout_tready // Product ready
);
  logic [16:0] q [3][$];
  logic [DW:0] qo [$];
  int seed = 27294;
  initial begin
    o_tvalid = 3'h0;
    o_dout_tready = 1'b0;
    for (int k = 0; k < 3; k++) begin
      o_word[k] = 17'h00000;
    end
  end
  // Offer queue heads, each held until taken
  always @(posedge i_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (o_tvalid[k] && i_tready[k] && i_aclken) begin
        void'(q[k].pop_front());
      end
      if (q[k].size() > 0) begin
        o_tvalid[k] <= 1'b1;
        o_word[k] <= q[k][0];
      end else begin
        o_tvalid[k] <= 1'b0;
        o_word[k] <= ~o_word[k];
      end
    end
  end
  // Collect products, ready as the mode says
  always @(posedge i_clk) begin
    if (i_dout_tvalid && o_dout_tready && i_aclken) begin
      qo.push_back({i_dout_tlast, i_dout_tdata});
    end
    o_dout_tready <= (i_mode == 2'd0)
      || (i_mode == 2'd1 && ($random(seed) & 1) == 0);
  end
endmodule
`default_nettype wire

/* File: sim/complex_multiplier_stream_tb.sv */
// Purpose: Self-checking bench for the complex multiplier
// Assumes: 8-bit operands, 12-bit output parts, rounding on
// Notes: Five low product bits are dropped
`timescale 1ns/100ps
`default_nettype none
module complex_multiplier_stream_tb import cms_pkg::*;;
  localparam int OW = 12;
  localparam int L = 5;
  logic clk = 0, rst = 1, srst_n = 1, cen = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, dv, dr, dl, cen_off = 0, cen_rand = 0;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] usr = 3'h0, du;
  bit rnd = 1'b1;
  logic [2:0] tv, tr, lv;
  logic [16:0] w [3];
  logic [15:0] wv [3] = '{16'h0, 16'h0, 16'h0};
  logic [23:0] dd;
  logic [1:0] pmode = 2'd0;
  int seed = 27294, n_fail = 0, check_count = 0, n_prod = 0;
  cms_top #(.AW(8), .BW(8), .OW(OW), .ROUND_RANDOM(1'b1), .HAS_C_LAST(1'b1))
    i_cms_top (
    .i_ref_clk(clk), .i_rst(rst), .i_stream_rst_n(srst_n), .i_aclken(cen),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_a_tvalid(tv[0]),
    .o_a_tready(tr[0]), .i_a_tdata(w[0][15:0]), .i_a_tlast(w[0][16]),
    .i_a_tuser(usr[0]), .i_b_tvalid(tv[1]), .o_b_tready(tr[1]),
    .i_b_tdata(w[1][15:0]), .i_b_tlast(w[1][16]), .i_b_tuser(usr[1]),
    .i_ctrl_tvalid(tv[2]), .o_ctrl_tready(tr[2]),
    .i_ctrl_tdata(w[2][7:0]), .i_ctrl_tlast(w[2][16]),
    .i_ctrl_tuser(usr[2]), .o_dout_tvalid(dv), .i_dout_tready(dr),
    .o_dout_tdata(dd), .o_dout_tlast(dl), .o_dout_tuser(du)
  );
  cms_partner #(.DW(24)) i_cms_partner (
    .i_clk(clk), .i_aclken(cen), .i_mode(pmode), .i_tready(tr),
    .o_tvalid(tv), .o_word(w), .i_dout_tvalid(dv), .i_dout_tdata(dd),
    .i_dout_tlast(dl), .o_dout_tready(dr)
  );
  // Clock and random clock enable
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cen <= !cen_off && (!cen_rand || ($random(seed) & 3) != 0);
    usr <= 3'($random(seed));
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic wr, input logic [11:0] a, input int d);
    int n;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      n_fail++;
      wrap_up;
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Offer words, model the product, compare it
  task automatic op(input logic [2:0] en, input int md, input bit take);
    logic [16:0] wd;
    logic lx;
    int re, im, r, n;
    for (int k = 0; k < 3; k++) begin
      if (en[k]) begin
        wd = $random(seed);
        wv[k] = wd[15:0];
        lv[k] = wd[16];
        i_cms_partner.q[k].push_back(wd);
      end
      if (en == 3'h7 && k == 0) begin
        repeat (10) @(posedge clk);
        chk(i_cms_partner.qo.size(), 0);
      end
    end
    re = $signed(wv[0][7:0]) * $signed(wv[1][7:0])
      - $signed(wv[0][15:8]) * $signed(wv[1][15:8]);
    im = $signed(wv[0][7:0]) * $signed(wv[1][15:8])
      + $signed(wv[0][15:8]) * $signed(wv[1][7:0]);
    r = wv[2][0] & rnd;
    re = (re + (1 << (L - 1)) - 1 + r) >>> L;
    im = (im + (1 << (L - 1)) - 1 + r) >>> L;
    case (md)
      1: lx = lv[0];
      2: lx = lv[1];
      3: lx = lv[2];
      4: lx = |lv;
      5: lx = &lv;
      default: lx = 1'b0;
    endcase
    n = 0;
    while (take && i_cms_partner.qo.size() == 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (take && i_cms_partner.qo.size() == 0) begin
      n_fail++;
      wrap_up;
    end
    if (take) begin
      chk(du, 3'h0);
      chk(i_cms_partner.qo.size(), 1);
      chk(i_cms_partner.qo.pop_front(), {lx, im[11:0], re[11:0]});
      n_prod++;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pstrb <= 4'he;
    apb(1'b1, CMS_ADDR_CTRL, 0);
    pstrb <= 4'hf;
    apb(1'b0, CMS_ADDR_CTRL, 0);
    chk(rd[4:0], CMS_CTRL_RST);
    apb(1'b0, 12'hffc, 0);
    chk(er, 1'b1);
    pmode <= 2'd1;
    cen_rand <= 1'b1;
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, CMS_ADDR_CTRL, 32'h11 | (m << 1));
      repeat (2) op(3'h7, m, 1'b1);
    end
    apb(1'b0, CMS_ADDR_COUNT, 0);
    chk(rd, n_prod);
    // Stalled product, then a one-cycle clear with enable low
    pmode <= 2'd2;
    cen_rand <= 1'b0;
    op(3'h7, 0, 1'b0);
    for (int n = 0; n < 100 && dv !== 1'b1; n++) @(posedge clk);
    chk(dv, 1'b1);
    if (dv !== 1'b1) wrap_up;
    cen_off <= 1'b1;
    repeat (2) @(posedge clk);
    srst_n <= 1'b0;
    @(posedge clk);
    srst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(dv, 1'b0);
    wv = '{16'h0, 16'h0, 16'h0};
    cen_off <= 1'b0;
    pmode <= 2'd0;
    rnd = 1'b0;
    apb(1'b1, CMS_ADDR_CTRL, 32'h0);
    for (int k = 0; k < 3; k++) op(3'h1 << k, 0, 1'b1);
    wrap_up;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
